// ==== bench/low_power_mode_controller_tb_top.sv ====
// Self-checking bench for the low-power mode controller.
`default_nettype none
module low_power_mode_controller_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, rst = 1'b1, irq = 1'b0, sup = 1'b0, req;
	logic [1:0]  boot = 2'h2, sel, mode, bsel;
	logic [24:0] src = '0;
	logic [10:0] o;
	int          fails = 0, num_checks = 0, cyc = 0;
	low_power_mode_controller dut_u (.I_CLK(clk), .I_RST(rst), .I_MODE_REQ(req), .I_MODE_SEL(sel), .I_ANY_IRQ(irq),
		.I_EXT_LINES(src[15:0]), .I_RTC_ALARM(src[16]), .I_RTC_TAMPER(src[17]), .I_RTC_STAMP(src[18]),
		.I_CMP_OUT(src[19]), .I_LVD_OUT(src[20]), .I_UART_WAKE(src[21]), .I_WDOG_RESET(src[22]),
		.I_WAKEUP_PIN(src[23]), .I_EXT_RESET_PIN_N(~src[24]), .I_SUPPLY_LOW(sup), .I_BOOT_PIN(boot),
		.O_MODE(mode), .O_CORE_CLK_EN(o[0]), .O_PERIPH_CLK_EN(o[1]), .O_RC8M_EN(o[2]), .O_XTAL_EN(o[3]),
		.O_PLL_EN(o[4]), .O_CORE_PWR_EN(o[5]), .O_REGULATOR_EN(o[6]), .O_RETAIN(o[7]), .O_CLKSEL_FORCE_RC(o[8]),
		.O_SYS_RESET(o[9]), .O_LVD_IRQ(o[10]), .O_BOOT_SEL(bsel));
	lpm_host_model host_u (.i_clk(clk), .o_req(req), .o_sel(sel));
	initial forever #4 clk = ~clk;
	task automatic chk(input string n, input logic [3:0] seen, input logic [3:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	always @(posedge clk) if (++cyc > 3000) begin
		fails++;
		report_and_stop();
	end
	initial begin
		step(2);
		rst = 1'b0;
		chk("sysrst", o[9], 1);
		step(8);
		chk("sysrst", o[9], 0);
		chk("boot", bsel, 2);
		host_u.request(2'h1);
		chk("sleep", {mode, o[1:0]}, 4'h6);
		irq = 1'b1;
		step(1);
		irq = 1'b0;
		chk("sleepwake", mode, 0);
		chk("runclk", o[3:0], 4'hf);
		chk("runpwr", o[7:4], 4'h7);
		// Every deep-sleep wake source in turn; each must also force the RC clock.
		for (int i = 0; i < 22; i++) begin
			host_u.request(2'h2);
			chk("deep", {mode, o[7], |o[4:0]}, 4'ha);
			src[i] = 1'b1;
			step(1);
			src[i] = 1'b0;
			chk("deepwake", {mode, o[8]}, 4'h1);
			step(1);
		end
		// Standby ignores a deep-only source and leaves on alarm, watchdog, pin edge, reset pin.
		foreach (src[b]) if (b == 16 || b > 21) begin
			host_u.request(2'h3);
			src[0] = 1'b1;
			step(1);
			src[0] = 1'b0;
			chk("stby", {mode, o[6:5]}, 4'hc);
			src[b] = 1'b1;
			step(1);
			src[b] = 1'b0;
			chk("stbywake", mode, 0);
			step(2);
			chk("wakerst", o[9], 1);
			step(10);
		end
		sup = 1'b1;
		src[20] = 1'b1;
		step(3);
		chk("lowsup", o[10:9], 3);
		report_and_stop();
	end
endmodule // low_power_mode_controller_tb_top
bind low_power_mode_controller lpm_sva #(.N_LINES(N_LINES)) chk_u (.*);
`default_nettype wire

// ==== bench/lpm_host_model.sv ====
// Processor-side model that issues mode requests.
`default_nettype none
module lpm_host_model (
	input  wire logic       i_clk,
	output var  logic       o_req = 1'b0,
	output var  logic [1:0] o_sel = 2'h0
);
	timeunit 1ns;
	timeprecision 1ps;
	// Request and selection are held for one edge; then the request drops and the selection is inverted.
	task automatic request(input logic [1:0] s);
		o_sel = s;
		o_req = 1'b1;
		@(posedge i_clk);
		#1 o_req = 1'b0;
		o_sel = ~s;
	endtask
endmodule // lpm_host_model
`default_nettype wire

// ==== bench/lpm_sva.sv ====
// Port checker for the low-power mode controller.
`default_nettype none
module lpm_sva #(parameter N_LINES = 16) (
	input wire logic I_CLK, I_RST, I_ANY_IRQ, I_SUPPLY_LOW, I_LVD_OUT, O_CORE_CLK_EN, O_PERIPH_CLK_EN,
	input wire logic O_RC8M_EN, O_XTAL_EN, O_PLL_EN, O_CORE_PWR_EN, O_REGULATOR_EN, O_RETAIN,
	input wire logic O_CLKSEL_FORCE_RC, O_SYS_RESET, O_LVD_IRQ,
	input wire logic [1:0] O_MODE,
	input wire logic [N_LINES-1:0] I_EXT_LINES
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	property p_slp; O_MODE == 2'h1 |-> !O_CORE_CLK_EN && O_PERIPH_CLK_EN; endproperty
	a_slp: assert property (p_slp) else $error("sleep clocks");
	property p_dsl; O_MODE == 2'h2 |-> !(O_CORE_CLK_EN | O_RC8M_EN | O_XTAL_EN | O_PLL_EN) && O_RETAIN; endproperty
	a_dsl: assert property (p_dsl) else $error("deep clocks");
	property p_dwk; O_MODE == 2'h2 && (I_ANY_IRQ || |I_EXT_LINES) |=> O_MODE == 2'h0; endproperty
	a_dwk: assert property (p_dwk) else $error("deep wake");
	property p_rc; O_MODE == 2'h0 && $past(O_MODE) == 2'h2 |-> O_CLKSEL_FORCE_RC; endproperty
	a_rc: assert property (p_rc) else $error("clock select");
	property p_sby; O_MODE == 2'h3 |-> !O_CORE_PWR_EN && !O_REGULATOR_EN && !O_XTAL_EN; endproperty
	a_sby: assert property (p_sby) else $error("standby power");
	property p_sup; I_SUPPLY_LOW [*2] |-> O_SYS_RESET; endproperty
	a_sup: assert property (p_sup) else $error("low supply");
	property p_lvd; I_LVD_OUT |=> O_LVD_IRQ; endproperty
	a_lvd: assert property (p_lvd) else $error("warning irq");
	property p_rel; $fell(I_RST) |-> O_SYS_RESET [*4]; endproperty
	a_rel: assert property (p_rel) else $error("reset hold");
endmodule // lpm_sva
`default_nettype wire

// ==== verilog/low_power_mode_controller.v ====
// Low-power mode controller: sleep, deep-sleep, standby, resets and boot select.
// Functional notes
// - Sleep gates only core clock; any event wakes. Code wakes sleep only on I_ANY_IRQ or a deep-sleep wake source.
// - Deep-sleep stops core clocks, fast oscillators, PLL.
// - Deep-sleep keeps SRAM and register contents.
// - Deep-sleep exits on any external-line wake event.
// - Deep-sleep exit selects internal 8 MHz RC.
// - Standby powers off core domain and regulator.
// - Standby exits on four sources only.
// - System reset covers core and all peripherals.
// - Hold reset while supply below threshold.
// - Low supply raises early warning interrupt.
// - Boot pin sampled at startup selects boot.
`include "lpm_map.vh"
`default_nettype none
module low_power_mode_controller #(
	parameter N_LINES = `NUM_EXT_LINES
) (
	input  wire               I_CLK,
	input  wire               I_RST,
	input  wire               I_MODE_REQ,
	input  wire [1:0]         I_MODE_SEL,
	input  wire               I_ANY_IRQ,
	input  wire [N_LINES-1:0] I_EXT_LINES,
	input  wire               I_RTC_ALARM,
	input  wire               I_RTC_TAMPER,
	input  wire               I_RTC_STAMP,
	input  wire               I_CMP_OUT,
	input  wire               I_LVD_OUT,
	input  wire               I_UART_WAKE,
	input  wire               I_EXT_RESET_PIN_N,
	input  wire               I_WDOG_RESET,
	input  wire               I_WAKEUP_PIN,
	input  wire               I_SUPPLY_LOW,
	input  wire [1:0]         I_BOOT_PIN,
	output reg  [1:0]         O_MODE,
	output reg                O_CORE_CLK_EN,
	output reg                O_PERIPH_CLK_EN,
	output reg                O_RC8M_EN,
	output reg                O_XTAL_EN,
	output reg                O_PLL_EN,
	output reg                O_CORE_PWR_EN,
	output reg                O_REGULATOR_EN,
	output reg                O_RETAIN,
	output reg                O_CLKSEL_FORCE_RC,
	output reg                O_SYS_RESET,
	output reg                O_LVD_IRQ,
	output reg  [1:0]         O_BOOT_SEL
);
	wire       deep_wake;
	wire       standby_wake;
	reg  [1:0] nxt_mode;
	reg        boot_done_ff;
	reg  [3:0] rst_cnt_ff;

	lpm_wake_qual #(
		.N_LINES(N_LINES)
	) u_wake (
		.i_clk            (I_CLK),
		.i_rst            (I_RST),
		.i_ext_lines      (I_EXT_LINES),
		.i_rtc_alarm      (I_RTC_ALARM),
		.i_rtc_tamper     (I_RTC_TAMPER),
		.i_rtc_stamp      (I_RTC_STAMP),
		.i_cmp_out        (I_CMP_OUT),
		.i_lvd_out        (I_LVD_OUT),
		.i_uart_wake      (I_UART_WAKE),
		.i_ext_reset_pin_n(I_EXT_RESET_PIN_N),
		.i_wdog_reset     (I_WDOG_RESET),
		.i_wakeup_pin     (I_WAKEUP_PIN),
		.o_deep_wake      (deep_wake),
		.o_standby_wake   (standby_wake)
	);

	always @* begin
		nxt_mode = O_MODE;
		case (O_MODE)
			`MODE_RUN: begin
				if (I_MODE_REQ && I_MODE_SEL != `MODE_RUN)
					nxt_mode = I_MODE_SEL;
			end
			`MODE_SLEEP: begin
				if (I_ANY_IRQ || deep_wake)
					nxt_mode = `MODE_RUN;
			end
			`MODE_DEEP: begin
				if (I_ANY_IRQ || deep_wake)
					nxt_mode = `MODE_RUN;
			end
			`MODE_STANDBY: begin
				if (standby_wake)
					nxt_mode = `MODE_RUN;
			end
			default: nxt_mode = `MODE_RUN;
		endcase
	end

	always @(posedge I_CLK) begin
		if (I_RST) begin
			O_MODE            <= `MODE_RUN;
			O_CORE_CLK_EN     <= 1'b0;
			O_PERIPH_CLK_EN   <= 1'b0;
			O_RC8M_EN         <= 1'b1;
			O_XTAL_EN         <= 1'b0;
			O_PLL_EN          <= 1'b0;
			O_CORE_PWR_EN     <= 1'b1;
			O_REGULATOR_EN    <= 1'b1;
			O_RETAIN          <= 1'b0;
			O_CLKSEL_FORCE_RC <= 1'b0;
			O_SYS_RESET       <= 1'b1;
			O_LVD_IRQ         <= 1'b0;
			O_BOOT_SEL        <= `BOOT_FLASH;
			boot_done_ff      <= 1'b0;
			rst_cnt_ff        <= `RST_HOLD_CYCLES;
		end else begin
			// The warning follows the detector level so software sees it as long as the supply stays low.
			O_LVD_IRQ <= I_LVD_OUT;
			// Reset is held while supply is low or after standby, then released after a short count.
			if (I_SUPPLY_LOW || (O_MODE == `MODE_STANDBY && nxt_mode == `MODE_RUN))
				rst_cnt_ff <= `RST_HOLD_CYCLES;
			else if (rst_cnt_ff != 4'h0)
				rst_cnt_ff <= rst_cnt_ff - 4'h1;
			O_SYS_RESET <= I_SUPPLY_LOW || (rst_cnt_ff != 4'h0);
			// The boot source is latched once, at the first edge with a good supply, and then kept.
			if (!boot_done_ff && !I_SUPPLY_LOW) begin
				boot_done_ff <= 1'b1;
				case (I_BOOT_PIN)
					2'h1:    O_BOOT_SEL <= `BOOT_SYSMEM;
					2'h2:    O_BOOT_SEL <= `BOOT_SRAM;
					default: O_BOOT_SEL <= `BOOT_FLASH;
				endcase
			end
			O_MODE <= nxt_mode;
			// The forced RC select marks the first run cycle after deep-sleep so the clock mux leaves the
			// stopped fast sources alone; it clears by itself at the next edge that stays in run.
			if (O_MODE == `MODE_DEEP && nxt_mode == `MODE_RUN)
				O_CLKSEL_FORCE_RC <= 1'b1;
			else if (nxt_mode == `MODE_RUN && O_MODE == `MODE_RUN)
				O_CLKSEL_FORCE_RC <= 1'b0;
			case (nxt_mode)
				`MODE_SLEEP: begin
					O_CORE_CLK_EN   <= 1'b0;
					O_PERIPH_CLK_EN <= 1'b1;
					O_RC8M_EN       <= 1'b1;
					O_XTAL_EN       <= 1'b1;
					O_PLL_EN        <= 1'b1;
					O_CORE_PWR_EN   <= 1'b1;
					O_REGULATOR_EN  <= 1'b1;
					O_RETAIN        <= 1'b0;
				end
				`MODE_DEEP: begin
					O_CORE_CLK_EN   <= 1'b0;
					O_PERIPH_CLK_EN <= 1'b0;
					O_RC8M_EN       <= 1'b0;
					O_XTAL_EN       <= 1'b0;
					O_PLL_EN        <= 1'b0;
					O_CORE_PWR_EN   <= 1'b1;
					O_REGULATOR_EN  <= 1'b1;
					O_RETAIN        <= 1'b1;
				end
				`MODE_STANDBY: begin
					O_CORE_CLK_EN   <= 1'b0;
					O_PERIPH_CLK_EN <= 1'b0;
					O_RC8M_EN       <= 1'b0;
					O_XTAL_EN       <= 1'b0;
					O_PLL_EN        <= 1'b0;
					O_CORE_PWR_EN   <= 1'b0;
					O_REGULATOR_EN  <= 1'b0;
					O_RETAIN        <= 1'b0;
				end
				default: begin
					O_CORE_CLK_EN   <= 1'b1;
					O_PERIPH_CLK_EN <= 1'b1;
					O_RC8M_EN       <= 1'b1;
					O_XTAL_EN       <= 1'b1;
					O_PLL_EN        <= 1'b1;
					O_CORE_PWR_EN   <= 1'b1;
					O_REGULATOR_EN  <= 1'b1;
					O_RETAIN        <= 1'b0;
				end
			endcase
		end
	end
endmodule // low_power_mode_controller
`default_nettype wire

// ==== verilog/lpm_map.vh ====
// Constants of the low-power mode controller.
`ifndef LPM_MAP_VH
`define LPM_MAP_VH
`define MODE_RUN        2'h0
`define MODE_SLEEP      2'h1
`define MODE_DEEP       2'h2
`define MODE_STANDBY    2'h3
`define BOOT_FLASH      2'h0
`define BOOT_SYSMEM     2'h1
`define BOOT_SRAM       2'h2
`define CLKSEL_RC8M     2'h0
`define NUM_EXT_LINES   16
`define RST_HOLD_CYCLES 4'h4
`endif

// ==== verilog/lpm_wake_qual.v ====
// Wake-source qualifier for deep-sleep and standby exit.
`include "lpm_map.vh"
`default_nettype none
module lpm_wake_qual #(
	parameter N_LINES = `NUM_EXT_LINES
) (
	input  wire               i_clk,
	input  wire               i_rst,
	input  wire [N_LINES-1:0] i_ext_lines,
	input  wire               i_rtc_alarm,
	input  wire               i_rtc_tamper,
	input  wire               i_rtc_stamp,
	input  wire               i_cmp_out,
	input  wire               i_lvd_out,
	input  wire               i_uart_wake,
	input  wire               i_ext_reset_pin_n,
	input  wire               i_wdog_reset,
	input  wire               i_wakeup_pin,
	output wire               o_deep_wake,
	output wire               o_standby_wake
);
	reg wakeup_pin_ff;

	// The edge detector resets high so that a pin already high at release is not taken as an edge.

	always @(posedge i_clk) begin
		if (i_rst)
			wakeup_pin_ff <= 1'b1;
		else
			wakeup_pin_ff <= i_wakeup_pin;
	end

	assign o_deep_wake = (|i_ext_lines) | i_rtc_alarm | i_rtc_tamper | i_rtc_stamp
		| i_cmp_out | i_lvd_out | i_uart_wake;
	// Only these four sources leave standby; the pin needs a rising edge.
	assign o_standby_wake = ~i_ext_reset_pin_n | i_rtc_alarm | i_wdog_reset
		| (i_wakeup_pin & ~wakeup_pin_ff);
endmodule // lpm_wake_qual
`default_nettype wire
